// ### rtl/pin_override.sv
/*
 One pin's override mux: register values, replaced by peripheral
 overrides where their enables stand.
 Assumes pin inputs are synchronous to the caller's clock.
*/
module pin_override (
   input wire logic outBit,
   input wire logic dirBit,
   input wire logic globalPullupDisable,
   input wire port_ovr_pkg::pin_ovr_s ovr,
   output logic pinOut,
   output logic pinOe,
   output logic pullupOn,
   output logic inBufOn
);
   import port_ovr_pkg::*;

   logic dirReg;
   logic pullReg;

   assign dirReg = dirBit;
   assign pullReg = ~dirBit & outBit & ~globalPullupDisable; // [RULE_16]
   // Override value wins whenever its enable is set
   assign pinOe = ovr.dirOvrEn ? ovr.dirOvrVal : dirReg; // [RULE_15]
   assign pinOut = ovr.valOvrEn ? ovr.valOvrVal : outBit; // [RULE_15]
   assign pullupOn = ovr.pullupOvrEn ? ovr.pullupOvrVal : pullReg; // [RULE_15]
   // Input buffer is on unless an override forces it
   assign inBufOn = ovr.inBufOvrEn ? ovr.inBufOvrVal : 1'b1;
endmodule

// ### rtl/port_alt_function_override.sv
/*
 Port register file (Ports A..E) with alternate-function override for
 Port D and Port E, reached over AXI4-Lite.
 Assumes pins are synchronous to clk; peripherals sit outside.
*/
// Function
// RULE_01 - Receiver on forces PD0 to input
// RULE_02 - PD0 pull-up kept by data bit, disable
// RULE_03 - Memory enable: PD7/PD6 output read/write strobes
// RULE_04 - PD5 compare A, PD4 serial clock values
// RULE_05 - Transmitter on: PD1 output, data, no pull-up
// RULE_06 - Irq one/zero force PD3/PD2 input buffer
// RULE_07 - Software sets PE2 direction for compare B
// RULE_08 - PE2 value replaced by compare B
// RULE_09 - Memory enable: PE1 output address latch strobe
// RULE_10 - PE0 feeds irq two, capture; buffer forced
// RULE_11 - Ports A-C data registers, reset zero
// RULE_12 - Ports A-C direction registers, reset zero
// RULE_13 - Ports A, B pin input registers read-only
// RULE_14 - PE1 latch strobe is address latch enable
// RULE_15 - Override enable replaces register-derived attribute
// RULE_16 - Pull-up only input, data one, not disabled
module port_alt_function_override #(
   parameter int ADDR_W = 8,
   parameter int PORT_W = 8,
   parameter int PE_W = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [PORT_W-1:0] portAIn,
   output logic [PORT_W-1:0] portAOut,
   output logic [PORT_W-1:0] portAOe,
   input wire logic [PORT_W-1:0] portBIn,
   output logic [PORT_W-1:0] portBOut,
   output logic [PORT_W-1:0] portBOe,
   input wire logic [PORT_W-1:0] portCIn,
   output logic [PORT_W-1:0] portCOut,
   output logic [PORT_W-1:0] portCOe,
   input wire logic [PORT_W-1:0] portDIn,
   output logic [PORT_W-1:0] portDOut,
   output logic [PORT_W-1:0] portDOe,
   output logic [PORT_W-1:0] portDPullup,
   input wire logic [PE_W-1:0] portEIn,
   output logic [PE_W-1:0] portEOut,
   output logic [PE_W-1:0] portEOe,
   output logic [PE_W-1:0] portEPullup,
   input wire port_ovr_pkg::periph_s periph,
   output port_ovr_pkg::periph_in_s periphIn
);
   import port_ovr_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [PORT_W-1:0] paOut;
      logic [PORT_W-1:0] paDir;
      logic [PORT_W-1:0] paPin;
      logic [PORT_W-1:0] pbOut;
      logic [PORT_W-1:0] pbDir;
      logic [PORT_W-1:0] pbPin;
      logic [PORT_W-1:0] pcOut;
      logic [PORT_W-1:0] pcDir;
      logic [PORT_W-1:0] pdOut;
      logic [PORT_W-1:0] pdDir;
      logic [PORT_W-1:0] pdPin;
      logic [PE_W-1:0] peOut;
      logic [PE_W-1:0] peDir;
      logic [PE_W-1:0] pePin;
      logic [CTRL_W-1:0] ctrl;
      logic awHeld;
      logic [ADDR_W-1:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic bErr;
      logic rValid;
      logic [31:0] rData;
      logic rErr;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   logic pullupDisable;
   logic memEnable;
   pin_ovr_s pdOvr [PORT_W];
   pin_ovr_s peOvr [PE_W];
   logic [PORT_W-1:0] pdInBuf;
   logic [PE_W-1:0] peInBuf;
   logic [PORT_W-1:0] pdPinGated;
   logic [PE_W-1:0] pePinGated;
   logic wrFire;
   logic wrHit;
   logic [PORT_W-1:0] wrByte;
   logic [31:0] rdWord;
   logic rdHit;

   assign pullupDisable = st_r.ctrl[CTRL_PUD];
   assign memEnable = st_r.ctrl[CTRL_XMEM];

   // ------------------------------------------------------------------
   // Override tables for Port D and Port E
   // ------------------------------------------------------------------
   always_comb begin
      pdOvr = '{default: '0};
      peOvr = '{default: '0};
      pdOvr[PD_RD].pullupOvrEn = memEnable; // [RULE_03]
      pdOvr[PD_RD].dirOvrEn = memEnable;
      pdOvr[PD_RD].dirOvrVal = 1'b1;
      pdOvr[PD_RD].valOvrEn = memEnable;
      pdOvr[PD_RD].valOvrVal = periph.memReadStrobe;
      pdOvr[PD_WR].pullupOvrEn = memEnable; // [RULE_03]
      pdOvr[PD_WR].dirOvrEn = memEnable;
      pdOvr[PD_WR].dirOvrVal = 1'b1;
      pdOvr[PD_WR].valOvrEn = memEnable;
      pdOvr[PD_WR].valOvrVal = periph.memWriteStrobe;
      pdOvr[PD_TIMER1_COMPARE_A_OUT].valOvrEn = periph.timer1CompareAEn; // [RULE_04]
      pdOvr[PD_TIMER1_COMPARE_A_OUT].valOvrVal = periph.timer1CompareAOut;
      pdOvr[PD_XCK].valOvrEn = periph.serialClkOutEn; // [RULE_04]
      pdOvr[PD_XCK].valOvrVal = periph.serialClkOut;
      pdOvr[PD_IRQ1].inBufOvrEn = st_r.ctrl[CTRL_IRQ1]; // [RULE_06]
      pdOvr[PD_IRQ1].inBufOvrVal = 1'b1;
      pdOvr[PD_IRQ0].inBufOvrEn = st_r.ctrl[CTRL_IRQ0]; // [RULE_06]
      pdOvr[PD_IRQ0].inBufOvrVal = 1'b1;
      pdOvr[PD_TXD].pullupOvrEn = periph.transmitterOn; // [RULE_05]
      pdOvr[PD_TXD].dirOvrEn = periph.transmitterOn;
      pdOvr[PD_TXD].dirOvrVal = 1'b1;
      pdOvr[PD_TXD].valOvrEn = periph.transmitterOn;
      pdOvr[PD_TXD].valOvrVal = periph.txData;
      // Receiver forces input but leaves the pull-up to software
      pdOvr[PD_RXD].dirOvrEn = periph.receiverOn; // [RULE_01]
      pdOvr[PD_RXD].pullupOvrEn = periph.receiverOn; // [RULE_02]
      pdOvr[PD_RXD].pullupOvrVal =
         st_r.pdOut[PD_RXD] & ~pullupDisable; // [RULE_02]
      // Compare B only reaches the pin once software set its direction
      peOvr[PE_TIMER1_COMPARE_B_OUT].valOvrEn = periph.timer1CompareBEn; // [RULE_08]
      peOvr[PE_TIMER1_COMPARE_B_OUT].valOvrVal = periph.timer1CompareBOut;
      peOvr[PE_ALE].pullupOvrEn = memEnable; // [RULE_09]
      peOvr[PE_ALE].dirOvrEn = memEnable;
      peOvr[PE_ALE].dirOvrVal = 1'b1;
      peOvr[PE_ALE].valOvrEn = memEnable;
      peOvr[PE_ALE].valOvrVal = periph.addrLatchStrobe; // [RULE_14]
      peOvr[PE_CAP].inBufOvrEn = st_r.ctrl[CTRL_IRQ2]; // [RULE_10]
      peOvr[PE_CAP].inBufOvrVal = 1'b1;
   end

   // ------------------------------------------------------------------
   // Pin muxes
   // ------------------------------------------------------------------
   for (genvar g = 0; g < PORT_W; g++) begin : g_pd
      pin_override u_pd (
         .outBit(st_r.pdOut[g]),
         .dirBit(st_r.pdDir[g]),
         .globalPullupDisable(pullupDisable),
         .ovr(pdOvr[g]),
         .pinOut(portDOut[g]),
         .pinOe(portDOe[g]),
         .pullupOn(portDPullup[g]),
         .inBufOn(pdInBuf[g])
      );
   end
   for (genvar g = 0; g < PE_W; g++) begin : g_pe
      pin_override u_pe (
         .outBit(st_r.peOut[g]),
         .dirBit(st_r.peDir[g]),
         .globalPullupDisable(pullupDisable),
         .ovr(peOvr[g]),
         .pinOut(portEOut[g]),
         .pinOe(portEOe[g]),
         .pullupOn(portEPullup[g]),
         .inBufOn(peInBuf[g])
      );
   end

   assign portAOut = st_r.paOut;
   assign portAOe = st_r.paDir;
   assign portBOut = st_r.pbOut;
   assign portBOe = st_r.pbDir;
   assign portCOut = st_r.pcOut;
   assign portCOe = st_r.pcDir;

   // Buffer off reads as low, so pins feeding peripherals see zero
   assign pdPinGated = portDIn & pdInBuf;
   assign pePinGated = portEIn & peInBuf;

   // Input routing from registered pin samples
   always_comb begin
      periphIn.extIrqZero = st_r.pdPin[PD_IRQ0]; // [RULE_06]
      periphIn.extIrqOne = st_r.pdPin[PD_IRQ1]; // [RULE_06]
      periphIn.extIrqTwo = st_r.pePin[PE_CAP]; // [RULE_10]
      periphIn.timer1CaptureIn = st_r.pePin[PE_CAP]; // [RULE_10]
      periphIn.rxdIn = st_r.pdPin[PD_RXD];
      periphIn.serialClkIn = st_r.pdPin[PD_XCK];
   end

   // ------------------------------------------------------------------
   // Register read decode
   // ------------------------------------------------------------------
   always_comb begin
      rdWord = '0;
      rdHit = 1'b1;
      unique case (s_axi_araddr)
         ADDR_PA_OUT: rdWord[PORT_W-1:0] = st_r.paOut;
         ADDR_PA_DIR: rdWord[PORT_W-1:0] = st_r.paDir;
         ADDR_PA_PIN: rdWord[PORT_W-1:0] = st_r.paPin; // [RULE_13]
         ADDR_PB_OUT: rdWord[PORT_W-1:0] = st_r.pbOut;
         ADDR_PB_DIR: rdWord[PORT_W-1:0] = st_r.pbDir;
         ADDR_PB_PIN: rdWord[PORT_W-1:0] = st_r.pbPin; // [RULE_13]
         ADDR_PC_OUT: rdWord[PORT_W-1:0] = st_r.pcOut;
         ADDR_PC_DIR: rdWord[PORT_W-1:0] = st_r.pcDir;
         ADDR_PD_OUT: rdWord[PORT_W-1:0] = st_r.pdOut;
         ADDR_PD_DIR: rdWord[PORT_W-1:0] = st_r.pdDir;
         ADDR_PD_PIN: rdWord[PORT_W-1:0] = st_r.pdPin;
         ADDR_PE_OUT: rdWord[PE_W-1:0] = st_r.peOut;
         ADDR_PE_DIR: rdWord[PE_W-1:0] = st_r.peDir;
         ADDR_PE_PIN: rdWord[PE_W-1:0] = st_r.pePin;
         ADDR_CTRL: rdWord[CTRL_W-1:0] = st_r.ctrl;
         default: rdHit = 1'b0;
      endcase
   end

   assign wrFire = st_r.awHeld & st_r.wHeld & ~st_r.bValid;
   assign wrHit = st_r.wStrb[0];
   assign wrByte = st_r.wData[PORT_W-1:0];

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.paPin = portAIn;
      st_nxt.pbPin = portBIn;
      st_nxt.pdPin = pdPinGated;
      st_nxt.pePin = pePinGated;
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.awHeld = 1'b1;
         st_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.wHeld = 1'b1;
         st_nxt.wData = s_axi_wdata;
         st_nxt.wStrb = s_axi_wstrb;
      end
      if (wrFire) begin
         st_nxt.awHeld = 1'b0;
         st_nxt.wHeld = 1'b0;
         st_nxt.bValid = 1'b1;
         st_nxt.bErr = 1'b0;
         // Only lane 0 holds data; other lanes are ignored
         unique case (st_r.awAddr)
            ADDR_PA_OUT: if (wrHit) st_nxt.paOut = wrByte; // [RULE_11]
            ADDR_PA_DIR: if (wrHit) st_nxt.paDir = wrByte; // [RULE_12]
            ADDR_PB_OUT: if (wrHit) st_nxt.pbOut = wrByte; // [RULE_11]
            ADDR_PB_DIR: if (wrHit) st_nxt.pbDir = wrByte; // [RULE_12]
            ADDR_PC_OUT: if (wrHit) st_nxt.pcOut = wrByte; // [RULE_11]
            ADDR_PC_DIR: if (wrHit) st_nxt.pcDir = wrByte; // [RULE_12]
            ADDR_PD_OUT: if (wrHit) st_nxt.pdOut = wrByte;
            ADDR_PD_DIR: if (wrHit) st_nxt.pdDir = wrByte;
            ADDR_PE_OUT: if (wrHit) st_nxt.peOut = st_r.wData[PE_W-1:0];
            ADDR_PE_DIR: if (wrHit) st_nxt.peDir = st_r.wData[PE_W-1:0];
            ADDR_CTRL: if (wrHit) st_nxt.ctrl = st_r.wData[CTRL_W-1:0];
            ADDR_PA_PIN, ADDR_PB_PIN, ADDR_PD_PIN, ADDR_PE_PIN: ;
            default: st_nxt.bErr = 1'b1;
         endcase
      end
      if (st_r.bValid && s_axi_bready) begin
         st_nxt.bValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.rValid = 1'b1;
         st_nxt.rData = rdWord;
         st_nxt.rErr = ~rdHit;
      end else if (st_r.rValid && s_axi_rready) begin
         st_nxt.rValid = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.paOut <= PORT_RESET;
         st_r.paDir <= PORT_RESET;
         st_r.pbOut <= PORT_RESET;
         st_r.pbDir <= PORT_RESET;
         st_r.pcOut <= PORT_RESET;
         st_r.pcDir <= PORT_RESET;
         st_r.pdOut <= PORT_RESET;
         st_r.pdDir <= PORT_RESET;
         st_r.peOut <= PE_RESET;
         st_r.peDir <= PE_RESET;
         st_r.ctrl <= CTRL_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = ~st_r.awHeld;
   assign s_axi_wready = ~st_r.wHeld;
   assign s_axi_bvalid = st_r.bValid;
   assign s_axi_bresp = st_r.bErr ? RESP_SLVERR : RESP_OKAY;
   assign s_axi_arready = ~st_r.rValid;
   assign s_axi_rvalid = st_r.rValid;
   assign s_axi_rdata = st_r.rData;
   assign s_axi_rresp = st_r.rErr ? RESP_SLVERR : RESP_OKAY;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_rx_input: assert property (@(posedge clk) // [RULE_01]
      disable iff (rst) periph.receiverOn |-> !portDOe[PD_RXD])
      else $error("PD0 driven while receiver on");
   chk_rx_pullup: assert property (@(posedge clk) // [RULE_02]
      disable iff (rst) periph.receiverOn |->
      portDPullup[PD_RXD] == (st_r.pdOut[PD_RXD] & ~pullupDisable))
      else $error("PD0 pull-up wrong under receiver");
   chk_mem_strobes: assert property (@(posedge clk) // [RULE_03]
      disable iff (rst) memEnable |-> portDOe[PD_RD] && portDOe[PD_WR] &&
      !portDPullup[PD_RD] && portDOut[PD_RD] == periph.memReadStrobe &&
      portDOut[PD_WR] == periph.memWriteStrobe)
      else $error("Memory strobes not on PD7/PD6");
   chk_cmp_a: assert property (@(posedge clk) // [RULE_04]
      disable iff (rst) periph.timer1CompareAEn |-> portDOut[PD_TIMER1_COMPARE_A_OUT] ==
      periph.timer1CompareAOut && portDOe[PD_TIMER1_COMPARE_A_OUT] == st_r.pdDir[PD_TIMER1_COMPARE_A_OUT])
      else $error("PD5 compare A wrong");
   chk_tx_pin: assert property (@(posedge clk) // [RULE_05]
      disable iff (rst) periph.transmitterOn |-> portDOe[PD_TXD] &&
      !portDPullup[PD_TXD] && portDOut[PD_TXD] == periph.txData)
      else $error("PD1 not carrying transmit data");
   chk_irq_route: assert property (@(posedge clk) // [RULE_06]
      disable iff (rst) st_r.ctrl[CTRL_IRQ0] |=>
      periphIn.extIrqZero == $past(portDIn[PD_IRQ0]))
      else $error("PD2 not routed to irq zero");
   chk_cmp_b: assert property (@(posedge clk) // [RULE_08]
      disable iff (rst) periph.timer1CompareBEn |->
      portEOut[PE_TIMER1_COMPARE_B_OUT] == periph.timer1CompareBOut)
      else $error("PE2 compare B wrong");
   chk_ale_pin: assert property (@(posedge clk) // [RULE_09]
      disable iff (rst) memEnable |-> portEOe[PE_ALE] &&
      !portEPullup[PE_ALE] && portEOut[PE_ALE] == periph.addrLatchStrobe)
      else $error("PE1 not carrying latch strobe");
   chk_cap_route: assert property (@(posedge clk) // [RULE_10]
      disable iff (rst) st_r.ctrl[CTRL_IRQ2] |=>
      periphIn.timer1CaptureIn == $past(portEIn[PE_CAP]) &&
      periphIn.extIrqTwo == periphIn.timer1CaptureIn)
      else $error("PE0 not routed");
   chk_pullup_reg: assert property (@(posedge clk) // [RULE_16]
      disable iff (rst) !periph.receiverOn && !periph.transmitterOn |->
      portDPullup[PD_TXD] == (~st_r.pdDir[PD_TXD] & st_r.pdOut[PD_TXD] &
      ~pullupDisable))
      else $error("Register pull-up wrong");
endmodule

// ### rtl/port_ovr_pkg.sv
/*
 Package for the port override block: register offsets, reset values,
 pin positions and bus carriers.
 Assumes a single 250 MHz clock and an AXI4-Lite register bus.
*/
package port_ovr_pkg;
   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_PA_OUT = 8'h00;
   localparam logic [7:0] ADDR_PA_DIR = 8'h04;
   localparam logic [7:0] ADDR_PA_PIN = 8'h08;
   localparam logic [7:0] ADDR_PB_OUT = 8'h0C;
   localparam logic [7:0] ADDR_PB_DIR = 8'h10;
   localparam logic [7:0] ADDR_PB_PIN = 8'h14;
   localparam logic [7:0] ADDR_PC_OUT = 8'h18;
   localparam logic [7:0] ADDR_PC_DIR = 8'h1C;
   localparam logic [7:0] ADDR_PD_OUT = 8'h20;
   localparam logic [7:0] ADDR_PD_DIR = 8'h24;
   localparam logic [7:0] ADDR_PE_OUT = 8'h28;
   localparam logic [7:0] ADDR_PE_DIR = 8'h2C;
   localparam logic [7:0] ADDR_CTRL = 8'h30;
   localparam logic [7:0] ADDR_PD_PIN = 8'h34;
   localparam logic [7:0] ADDR_PE_PIN = 8'h38;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [2:0] PE_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Control register fields
   localparam int CTRL_PUD = 0;
   localparam int CTRL_XMEM = 1;
   localparam int CTRL_IRQ0 = 2;
   localparam int CTRL_IRQ1 = 3;
   localparam int CTRL_IRQ2 = 4;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   // Pin positions on Port D and Port E
   localparam int PD_RXD = 0;
   localparam int PD_TXD = 1;
   localparam int PD_IRQ0 = 2;
   localparam int PD_IRQ1 = 3;
   localparam int PD_XCK = 4;
   localparam int PD_TIMER1_COMPARE_A_OUT = 5;
   localparam int PD_WR = 6;
   localparam int PD_RD = 7;
   localparam int PE_CAP = 0;
   localparam int PE_ALE = 1;
   localparam int PE_TIMER1_COMPARE_B_OUT = 2;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic pullupOvrEn;
      logic pullupOvrVal;
      logic dirOvrEn;
      logic dirOvrVal;
      logic valOvrEn;
      logic valOvrVal;
      logic inBufOvrEn;
      logic inBufOvrVal;
   } pin_ovr_s;

   typedef struct packed {
      logic receiverOn;
      logic transmitterOn;
      logic txData;
      logic timer1CompareAEn;
      logic timer1CompareAOut;
      logic timer1CompareBEn;
      logic timer1CompareBOut;
      logic serialClkOutEn;
      logic serialClkOut;
      logic memReadStrobe;
      logic memWriteStrobe;
      logic addrLatchStrobe;
   } periph_s;

   typedef struct packed {
      logic extIrqZero;
      logic extIrqOne;
      logic extIrqTwo;
      logic timer1CaptureIn;
      logic rxdIn;
      logic serialClkIn;
   } periph_in_s;
endpackage

// ### verification/pin_board.sv
/*
 Board model for the Port D and Port E pins: resolves each pin level.
 Assumes the bench supplies the level that outside parts drive.
*/
module pin_board (
   input wire logic [7:0] dOut,
   input wire logic [7:0] dOe,
   input wire logic [7:0] dPullup,
   input wire logic [7:0] dExt,
   input wire logic [2:0] eOut,
   input wire logic [2:0] eOe,
   input wire logic [2:0] ePullup,
   input wire logic [2:0] eExt,
   output logic [7:0] dLevel,
   output logic [2:0] eLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   // Device drive wins; an undriven pin sees pull-up or the outside part
   assign dLevel = (dOe & dOut) | (~dOe & (dPullup | dExt));
   assign eLevel = (eOe & eOut) | (~eOe & (ePullup | eExt));
endmodule

// ### verification/port_alt_function_override_tb.sv
/*
 Self-checking bench for the port override block over AXI4-Lite.
 Assumes the register map and control bits of the package.
*/
module port_alt_function_override_tb;
   import port_ovr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [7:0] portAIn = 8'h00, portBIn = 8'h00, portCIn = 8'h00;
   logic [7:0] dExt = 8'h00;
   logic [2:0] eExt = 3'h0;
   logic [7:0] portAOut, portAOe, portBOut, portBOe, portCOut, portCOe;
   logic [7:0] portDIn, portDOut, portDOe, portDPullup;
   logic [2:0] portEIn, portEOut, portEOe, portEPullup;
   periph_s periph = '0;
   periph_s p;
   periph_in_s periphIn;
   logic [31:0] rv;
   int failures = 0, n_checks = 0, cyc = 0;

   always #2 clk = ~clk;

   port_alt_function_override dut (.clk, .rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .portAIn, .portAOut, .portAOe, .portBIn, .portBOut, .portBOe,
      .portCIn, .portCOut, .portCOe, .portDIn, .portDOut, .portDOe,
      .portDPullup, .portEIn, .portEOut, .portEOe, .portEPullup,
      .periph, .periphIn);

   pin_board board (.dOut(portDOut), .dOe(portDOe), .dPullup(portDPullup),
      .dExt, .eOut(portEOut), .eOe(portEOe), .ePullup(portEPullup),
      .eExt, .dLevel(portDIn), .eLevel(portEIn));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input string n, input logic [63:0] e,
                      input logic [63:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // Upper data bits are set on purpose: only the low byte may count
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'hFFFFFF, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
      chk("bresp", RESP_OKAY, s_axi_bresp);
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rv = s_axi_rdata;
            rr = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rdc(input string n, input logic [7:0] a,
                      input logic [31:0] e);
      rd(a);
      chk(n, e, rv);
   endtask

   task automatic setp(input periph_s v);
      @(posedge clk);
      periph <= v;
      @(negedge clk);
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_regs;
      logic [7:0] ad [6] = '{ADDR_PA_OUT, ADDR_PA_DIR, ADDR_PB_OUT,
                             ADDR_PB_DIR, ADDR_PC_OUT, ADDR_PC_DIR};
      for (int i = 0; i < 6; i++) begin
         rdc("reset value", ad[i], 32'h0);
         wr(ad[i], 8'hA0 + 8'(i));
         rdc("readback", ad[i], 8'hA0 + 8'(i));
      end
      chk("ports A-C", 48'hA0A1A2A3A4A5, {portAOut, portAOe, portBOut,
          portBOe, portCOut, portCOe});
      $display("done registers");
   endtask

   task automatic t_pins;
      @(posedge clk);
      portAIn <= 8'hC3;
      portBIn <= 8'h69;
      portCIn <= 8'h5A;
      rdc("pin A", ADDR_PA_PIN, 32'hC3);
      wr(ADDR_PB_PIN, 8'h00);
      rdc("pin B", ADDR_PB_PIN, 32'h69);
      rd(8'hFC);
      chk("unmapped", RESP_SLVERR, {rv, 30'h0, rr});
      $display("done pin sense");
   endtask

   task automatic t_rx;
      wr(ADDR_PD_DIR, 8'hFF);
      wr(ADDR_PD_OUT, 8'h01);
      p = '0;
      p.receiverOn = 1'b1;
      setp(p);
      chk("rx oe pullup", 2'b01,
          {portDOe[0], portDPullup[0]});
      wr(ADDR_CTRL, 8'h01);
      chk("rx pullup off", 1'b0, portDPullup[0]);
      wr(ADDR_CTRL, 8'h00);
      setp('0);
      chk("dir back", 1'b1, portDOe[0]);
      wr(ADDR_PD_DIR, 8'h00);
      chk("pullups", 8'h01, portDPullup);
      $display("done receiver");
   endtask

   task automatic t_tx;
      wr(ADDR_PD_OUT, 8'h02);
      p = '0;
      p.transmitterOn = 1'b1;
      p.txData = 1'b1;
      setp(p);
      chk("tx drive", 3'b110,
          {portDOe[1], portDOut[1], portDPullup[1]});
      p.txData = 1'b0;
      setp(p);
      chk("tx data", 1'b0, portDOut[1]);
      setp('0);
      chk("tx off", 3'b011,
          {portDOe[1], portDOut[1], portDPullup[1]});
      $display("done transmitter");
   endtask

   task automatic t_xmem;
      wr(ADDR_PD_OUT, 8'hC0);
      wr(ADDR_PE_OUT, 8'h02);
      wr(ADDR_CTRL, 8'h02);
      p = '0;
      p.memReadStrobe = 1'b1;
      p.addrLatchStrobe = 1'b1;
      setp(p);
      chk("mem D", 6'b111000, {portDOe[7:6], portDOut[7:6],
          portDPullup[7:6]});
      chk("mem E", 3'b110,
          {portEOe[1], portEOut[1], portEPullup[1]});
      p.memReadStrobe = 1'b0;
      p.memWriteStrobe = 1'b1;
      p.addrLatchStrobe = 1'b0;
      setp(p);
      chk("strobes", 3'b010,
          {portDOut[7:6], portEOut[1]});
      wr(ADDR_CTRL, 8'h00);
      chk("mem off", 5'b00111, {portDOe[7:6], portDPullup[7:6],
          portEPullup[1]});
      setp('0);
      $display("done memory");
   endtask

   task automatic t_cmp;
      wr(ADDR_PD_OUT, 8'h00);
      wr(ADDR_PD_DIR, 8'h30);
      p = '0;
      p.timer1CompareAEn = 1'b1;
      p.timer1CompareAOut = 1'b1;
      p.serialClkOutEn = 1'b1;
      p.serialClkOut = 1'b1;
      setp(p);
      chk("D5 D4", 4'hF, {portDOe[5:4], portDOut[5:4]});
      wr(ADDR_PD_DIR, 8'h00);
      chk("D5 D4 dir", 4'h3, {portDOe[5:4], portDOut[5:4]});
      wr(ADDR_PE_DIR, 8'h04);
      p = '0;
      p.timer1CompareBEn = 1'b1;
      p.timer1CompareBOut = 1'b1;
      setp(p);
      chk("E2", 2'b11, {portEOe[2], portEOut[2]});
      p.timer1CompareBOut = 1'b0;
      setp(p);
      chk("E2 value", 1'b0, portEOut[2]);
      setp('0);
      $display("done compare");
   endtask

   task automatic t_irq;
      @(posedge clk);
      dExt <= 8'h1D;
      eExt <= 3'h1;
      repeat (2) @(negedge clk);
      chk("irq off", 4'hF, {periphIn.extIrqZero, periphIn.extIrqOne,
          periphIn.extIrqTwo, periphIn.timer1CaptureIn});
      chk("rx sclk", 2'b11,
          {periphIn.rxdIn, periphIn.serialClkIn});
      wr(ADDR_CTRL, 8'h1C);
      repeat (2) @(negedge clk);
      chk("irq on", 4'hF, {periphIn.extIrqZero, periphIn.extIrqOne,
          periphIn.extIrqTwo, periphIn.timer1CaptureIn});
      rdc("ctrl", ADDR_CTRL, 32'h1C);
      @(posedge clk);
      dExt <= 8'h04;
      eExt <= 3'h0;
      repeat (2) @(negedge clk);
      chk("irq follow", 4'h8, {periphIn.extIrqZero, periphIn.extIrqOne,
          periphIn.extIrqTwo, periphIn.timer1CaptureIn});
      rdc("pin D", ADDR_PD_PIN, 32'h04);
      rdc("pin E", ADDR_PE_PIN, 32'h02);
      wr(ADDR_CTRL, 8'h00);
      $display("done interrupts");
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_pins();
      t_rx();
      t_tx();
      t_xmem();
      t_cmp();
      t_irq();
      conclude();
   end
endmodule
